// [logic/stbirq_map.svh]
// Purpose: Offsets, field positions, reset values and counts of the short-to-battery interrupt page
// Assumes: Byte-wide registers on the device register page, 8-bit offsets
// Notes: Definitions only
`ifndef STBIRQ_MAP_SVH
`define STBIRQ_MAP_SVH

`define STBIRQ_OFS_IRQ_CFG 8'h40
`define STBIRQ_OFS_STATUS 8'h53
`define STBIRQ_OFS_CLEAR 8'h54
`define STBIRQ_OFS_UNMASK 8'h55

`define STBIRQ_BIT_CH1 1
`define STBIRQ_BIT_CH2 3
`define STBIRQ_LEN_LSB 6
`define STBIRQ_LEN_MSB 7
`define STBIRQ_DRV_LSB 0
`define STBIRQ_DRV_MSB 1

`define STBIRQ_RST_UNMASK 2'h0
`define STBIRQ_RST_STATUS 2'h0
`define STBIRQ_RST_LEN 2'h0
`define STBIRQ_RST_DRV 2'h0
`define STBIRQ_RDATA_ZERO 8'h00

// Interrupt pulse lengths, in crystal periods; one crystal period is one sys_clk_in cycle
`define STBIRQ_PULSE_3 6'h03
`define STBIRQ_PULSE_15 6'h0F
`define STBIRQ_PULSE_63 6'h3F

`endif

// [logic/stbirq_pkg.sv]
// Purpose: Types shared by the short-to-battery interrupt logic
// Assumes: Nothing beyond SystemVerilog
// Notes: Numbers live in stbirq_map.svh
package stbirq_pkg;

  typedef enum logic [1:0] {
    STBIRQ_LEN_3,
    STBIRQ_LEN_15,
    STBIRQ_LEN_63,
    STBIRQ_LEN_LEVEL
  } stbirq_len_t;

  typedef enum logic [1:0] {
    STBIRQ_DRV_OPEN_DRAIN,
    STBIRQ_DRV_LOW_ACTIVE,
    STBIRQ_DRV_HIGH_ACTIVE,
    STBIRQ_DRV_RESERVED
  } stbirq_drv_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stbirq_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } stbirq_rsp_t;

  typedef struct packed {
    logic o;
    logic oe;
  } stbirq_pin_t;

endpackage

// [logic/stbirq_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for comparator levels
// Assumes: Inputs are asynchronous to sys_clk_in
// Notes: A change is taken once the second and third stages agree
module stbirq_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  // First stage feeds only the second one
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      meta_r <= async_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_out[i] <= stage3_r[i];
        end
      end
    end
  end
endmodule

// [logic/stbirq_top.sv]
// Purpose: Short-to-battery diagnostic interrupt logic for two sense channels
// Assumes: Register page access arrives already decoded from the serial control port
// Notes: Comparator outputs are asynchronous; the interrupt pin is a two-signal pad
// Notes on behaviour
// - Unmask bits at 0x55 bit 1 and bit 3; 0 masks, reset 0.
// - A detected event sets that channel's status bit from 0 to 1.
// - Status stays 1 after the fault goes; only a software clear drops it.
// - Software writes 1 to a clear bit; the device then drops that status.
// - Channel-one clear at 0x54 bit 1, write-only, self clearing.
// - Writing 0 to a clear bit leaves the status alone.
// - Status bits read-only at 0x53 bit 1 and bit 3.
// - An event is the comparator reporting the pin above its threshold.
// - An unmasked active status also asserts the interrupt pin.
// - Channel-two clear at 0x54 bit 3, same behaviour as channel one.
// - Pulse length at 0x40 bits 7:6: 3, 15, 63 periods or until cleared.
// - Drive style at 0x40 bits 1:0: open drain, low, high, reserved.
`include "stbirq_map.svh"

module stbirq_top (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic sense_pin_one_in,
  input wire logic sense_pin_two_in,
  input wire stbirq_pkg::stbirq_req_t reg_req_in,
  output stbirq_pkg::stbirq_rsp_t reg_rsp_out,
  output logic [1:0] sense_latched_out,
  output stbirq_pkg::stbirq_pin_t irq_out_n_out
);
  import stbirq_pkg::*;

  logic [1:0] above_thr;
  logic [1:0] sense_event;
  logic [1:0] clear_hit;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] unmask_r;
  stbirq_len_t len_r;
  stbirq_drv_t drv_r;
  logic [1:0] src_r;
  logic [1:0] src_nxt;
  logic trigger;
  logic irq_active_r;
  logic irq_active_nxt;
  logic [5:0] pulse_cnt_r;
  logic [5:0] pulse_cnt_nxt;
  stbirq_rsp_t rsp_nxt;
  stbirq_pin_t pin_nxt;

  function automatic logic wr_to(input stbirq_req_t req, input logic [7:0] ofs);
    wr_to = req.wr && (req.addr == ofs);
  endfunction

  function automatic logic [5:0] pulse_len(input stbirq_len_t len);
    unique case (len)
      STBIRQ_LEN_3: pulse_len = `STBIRQ_PULSE_3;
      STBIRQ_LEN_15: pulse_len = `STBIRQ_PULSE_15;
      STBIRQ_LEN_63: pulse_len = `STBIRQ_PULSE_63;
      STBIRQ_LEN_LEVEL: pulse_len = `STBIRQ_PULSE_3;
    endcase
  endfunction

  // Comparator levels cross into the crystal domain here
  stbirq_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({sense_pin_two_in, sense_pin_one_in}),
    .level_out(above_thr)
  );

  // A level above threshold counts as an event every cycle it is seen
  assign sense_event = above_thr;

  // Clear strobes exist only during the write cycle, never stored
  assign clear_hit[0] = wr_to(reg_req_in, `STBIRQ_OFS_CLEAR) &&
                        reg_req_in.wdata[`STBIRQ_BIT_CH1];
  assign clear_hit[1] = wr_to(reg_req_in, `STBIRQ_OFS_CLEAR) &&
                        reg_req_in.wdata[`STBIRQ_BIT_CH2];

  // Set wins over clear, so an event in the clearing cycle is kept
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (sense_event[i]) begin
        status_nxt[i] = 1'b1;
      end else if (clear_hit[i]) begin
        status_nxt[i] = 1'b0;
      end else begin
        status_nxt[i] = status_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_r <= `STBIRQ_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unmask_r <= `STBIRQ_RST_UNMASK;
    end else if (wr_to(reg_req_in, `STBIRQ_OFS_UNMASK)) begin
      unmask_r <= {reg_req_in.wdata[`STBIRQ_BIT_CH2], reg_req_in.wdata[`STBIRQ_BIT_CH1]};
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      len_r <= stbirq_len_t'(`STBIRQ_RST_LEN);
      drv_r <= stbirq_drv_t'(`STBIRQ_RST_DRV);
    end else if (wr_to(reg_req_in, `STBIRQ_OFS_IRQ_CFG)) begin
      len_r <= stbirq_len_t'(reg_req_in.wdata[`STBIRQ_LEN_MSB:`STBIRQ_LEN_LSB]);
      drv_r <= stbirq_drv_t'(reg_req_in.wdata[`STBIRQ_DRV_MSB:`STBIRQ_DRV_LSB]);
    end
  end

  // Unmasked sources; a fresh rise is what fires a timed pulse
  assign src_nxt = status_nxt & unmask_r;
  assign trigger = |(src_nxt & ~src_r);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_r <= 2'h0;
    end else begin
      src_r <= src_nxt;
    end
  end

  // Retrigger reloads the count, so bursts stretch the pulse rather than chop it
  always_comb begin
    irq_active_nxt = irq_active_r;
    pulse_cnt_nxt = pulse_cnt_r;
    if (len_r == STBIRQ_LEN_LEVEL) begin
      irq_active_nxt = |src_nxt;
      pulse_cnt_nxt = 6'h00;
    end else if (trigger) begin
      irq_active_nxt = 1'b1;
      pulse_cnt_nxt = pulse_len(len_r) - 6'h01;
    end else if (irq_active_r) begin
      if (pulse_cnt_r == 6'h00) begin
        irq_active_nxt = 1'b0;
      end else begin
        pulse_cnt_nxt = pulse_cnt_r - 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_active_r <= 1'b0;
      pulse_cnt_r <= 6'h00;
    end else begin
      irq_active_r <= irq_active_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // Reserved drive style leaves the pad undriven rather than guess a polarity
  always_comb begin
    pin_nxt.o = 1'b1;
    pin_nxt.oe = 1'b0;
    unique case (drv_r)
      STBIRQ_DRV_OPEN_DRAIN: begin
        pin_nxt.o = 1'b0;
        pin_nxt.oe = irq_active_nxt;
      end
      STBIRQ_DRV_LOW_ACTIVE: begin
        pin_nxt.o = ~irq_active_nxt;
        pin_nxt.oe = 1'b1;
      end
      STBIRQ_DRV_HIGH_ACTIVE: begin
        pin_nxt.o = irq_active_nxt;
        pin_nxt.oe = 1'b1;
      end
      STBIRQ_DRV_RESERVED: begin
        pin_nxt.o = 1'b1;
        pin_nxt.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out_n_out <= '{o: 1'b1, oe: 1'b0};
    end else begin
      irq_out_n_out <= pin_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sense_latched_out <= `STBIRQ_RST_STATUS;
    end else begin
      sense_latched_out <= status_nxt;
    end
  end

  // Read port: one-cycle registered answer; unmapped and write-only read zero
  always_comb begin
    rsp_nxt.valid = reg_req_in.rd;
    rsp_nxt.data = `STBIRQ_RDATA_ZERO;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        `STBIRQ_OFS_IRQ_CFG: begin
          rsp_nxt.data[`STBIRQ_LEN_MSB:`STBIRQ_LEN_LSB] = len_r;
          rsp_nxt.data[`STBIRQ_DRV_MSB:`STBIRQ_DRV_LSB] = drv_r;
        end
        `STBIRQ_OFS_STATUS: begin
          rsp_nxt.data[`STBIRQ_BIT_CH1] = status_r[0];
          rsp_nxt.data[`STBIRQ_BIT_CH2] = status_r[1];
        end
        `STBIRQ_OFS_UNMASK: begin
          rsp_nxt.data[`STBIRQ_BIT_CH1] = unmask_r[0];
          rsp_nxt.data[`STBIRQ_BIT_CH2] = unmask_r[1];
        end
        default: begin
          rsp_nxt.data = `STBIRQ_RDATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rsp_out <= '0;
    end else begin
      reg_rsp_out <= rsp_nxt;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Counts the cycles of the current pulse; a retrigger starts it over
  logic [6:0] hold_cnt_r;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_cnt_r <= 7'h00;
    end else if (!irq_active_nxt) begin
      hold_cnt_r <= 7'h00;
    end else if (trigger) begin
      hold_cnt_r <= 7'h01;
    end else begin
      hold_cnt_r <= hold_cnt_r + 7'h01;
    end
  end

  sequence clear_one_s;
    wr_to(reg_req_in, `STBIRQ_OFS_CLEAR) && reg_req_in.wdata[`STBIRQ_BIT_CH1];
  endsequence

  sequence quiet_one_s;
    !sense_event[0];
  endsequence

  event_sets_a: assert property (
    sense_event[0] |=> status_r[0])
    else $error("Channel one event did not set status");

  status_holds_a: assert property (
    status_r[1] && !clear_hit[1] |=> status_r[1])
    else $error("Channel two status dropped without clear");

  clear_works_a: assert property (
    clear_one_s and quiet_one_s |=> !status_r[0])
    else $error("Channel one clear did not drop status");

  zero_write_a: assert property (
    wr_to(reg_req_in, `STBIRQ_OFS_CLEAR) && !reg_req_in.wdata[`STBIRQ_BIT_CH2]
      && !sense_event[1] |=> status_r[1] == $past(status_r[1]))
    else $error("Writing zero changed channel two status");

  event_wins_a: assert property (
    clear_hit[0] && sense_event[0] |=> status_r[0])
    else $error("Clear beat a simultaneous event");

  status_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `STBIRQ_OFS_STATUS
      |=> reg_rsp_out.valid && reg_rsp_out.data[`STBIRQ_BIT_CH2] == $past(status_r[1]))
    else $error("Status read returned wrong value");

  mask_gates_a: assert property (
    unmask_r == 2'h0 && len_r == STBIRQ_LEN_LEVEL |=> !irq_active_r)
    else $error("Masked status drove the interrupt");

  pin_fires_a: assert property (
    trigger |=> irq_active_r && (irq_out_n_out.oe || $past(drv_r) == STBIRQ_DRV_RESERVED))
    else $error("Unmasked event did not fire interrupt");

  pulse_len_a: assert property (
    irq_active_r && !irq_active_nxt && len_r != STBIRQ_LEN_LEVEL
      |-> hold_cnt_r == {1'b0, pulse_len(len_r)})
    else $error("Interrupt pulse ran past its length");

  drain_idle_a: assert property (
    drv_r == STBIRQ_DRV_OPEN_DRAIN ##1 !irq_active_r |-> !irq_out_n_out.oe)
    else $error("Open drain pad driven while idle");
endmodule

// [verif/short_to_battery_irq_tb.sv]
// Purpose: Self-checking bench for the short-to-battery interrupt logic
// Assumes: Inputs change on the falling edge of sys_clk_in
// Notes: Comparator levels come through the far-side model
`include "stbirq_map.svh"
module short_to_battery_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stbirq_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic fault_one = 1'b0;
  logic fault_two = 1'b0;
  logic sense_one, sense_two, pad_level;
  logic [1:0] latched;
  stbirq_req_t req = '0;
  stbirq_rsp_t rsp;
  stbirq_pin_t pin;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [5:0] plen [3] = '{`STBIRQ_PULSE_3, `STBIRQ_PULSE_15, `STBIRQ_PULSE_63};

  always #12.5 sys_clk = ~sys_clk;

  stbirq_top stbirq_top_i (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
    .sense_pin_one_in(sense_one), .sense_pin_two_in(sense_two), .reg_req_in(req),
    .reg_rsp_out(rsp), .sense_latched_out(latched), .irq_out_n_out(pin));
  stbirq_far_model stbirq_far_model_i (.fault_one_in(fault_one), .fault_two_in(fault_two),
    .pad_in(pin), .sense_pin_one_out(sense_one), .sense_pin_two_out(sense_two),
    .pad_level_out(pad_level));

  task automatic conclude();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Long enough for every scenario, short enough to cut a hang quickly
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Request pulse lasts one cycle; a free cycle follows so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    req = '0;
    @(negedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    int n;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    req = '0;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    check(rsp.valid === 1'b1 ? rsp.data : 8'hEE, e, "read data");
    @(negedge sys_clk);
  endtask

  task automatic wait_lat(input logic [1:0] e);
    int n;
    n = 0;
    while (latched !== e && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    check({6'h00, latched}, {6'h00, e}, "latched status");
  endtask

  // Pad fields {o, oe} for a drive style and activity
  function automatic logic [1:0] exp_pin(input int d, input logic act);
    case (d)
      0: exp_pin = {1'b0, act};
      1: exp_pin = {~act, 1'b1};
      2: exp_pin = {act, 1'b1};
      default: exp_pin = 2'b10;
    endcase
  endfunction

  task automatic test_regs();
    rd_chk(`STBIRQ_OFS_UNMASK, `STBIRQ_RDATA_ZERO);
    rd_chk(`STBIRQ_OFS_STATUS, `STBIRQ_RDATA_ZERO);
    rd_chk(`STBIRQ_OFS_CLEAR, `STBIRQ_RDATA_ZERO);
    rd_chk(`STBIRQ_OFS_IRQ_CFG, `STBIRQ_RDATA_ZERO);
    rd_chk(8'h56, `STBIRQ_RDATA_ZERO);
    check({7'h00, pad_level}, 8'h01, "pad idle");
    wr(`STBIRQ_OFS_UNMASK, 8'hFF);
    rd_chk(`STBIRQ_OFS_UNMASK, 8'h0A);
    wr(`STBIRQ_OFS_STATUS, 8'hFF);
    rd_chk(`STBIRQ_OFS_STATUS, `STBIRQ_RDATA_ZERO);
    wr(`STBIRQ_OFS_UNMASK, 8'h00);
  endtask

  // Masked, level mode: a leaking mask would hold the pad low
  task automatic test_sticky(input int ch);
    logic [7:0] b;
    b = (ch == 1) ? 8'h02 : 8'h08;
    wr(`STBIRQ_OFS_IRQ_CFG, 8'hC0);
    if (ch == 1) fault_one = 1'b1;
    else fault_two = 1'b1;
    wait_lat(ch == 1 ? 2'b01 : 2'b10);
    fault_one = 1'b0;
    fault_two = 1'b0;
    idle(8);
    rd_chk(`STBIRQ_OFS_STATUS, b);
    check({7'h00, pad_level}, 8'h01, "masked pad");
    wr(`STBIRQ_OFS_CLEAR, 8'h00);
    rd_chk(`STBIRQ_OFS_STATUS, b);
    wr(`STBIRQ_OFS_CLEAR, b);
    rd_chk(`STBIRQ_OFS_STATUS, `STBIRQ_RDATA_ZERO);
    rd_chk(`STBIRQ_OFS_CLEAR, `STBIRQ_RDATA_ZERO);
  endtask

  task automatic test_pulse();
    int n;
    for (int l = 0; l < 3; l++) begin
      wr(`STBIRQ_OFS_IRQ_CFG, {l[1:0], 6'h00});
      wr(`STBIRQ_OFS_UNMASK, 8'h08);
      fault_two = 1'b1;
      n = 0;
      while (pad_level !== 1'b0 && n < 20) begin
        @(negedge sys_clk);
        n++;
      end
      fault_two = 1'b0;
      n = 0;
      while (pad_level === 1'b0 && n < 100) begin
        @(negedge sys_clk);
        n++;
      end
      check(n[7:0], {2'h0, plen[l]}, "pulse length");
      // Let the comparator level drain through the synchroniser, else the event beats the clear
      idle(8);
      wr(`STBIRQ_OFS_CLEAR, 8'h08);
      wait_lat(2'b00);
      wr(`STBIRQ_OFS_UNMASK, 8'h00);
    end
  endtask

  task automatic test_drive();
    for (int d = 0; d < 4; d++) begin
      wr(`STBIRQ_OFS_IRQ_CFG, {6'h30, d[1:0]});
      wr(`STBIRQ_OFS_UNMASK, 8'h02);
      check({6'h00, pin.o, pin.oe}, {6'h00, exp_pin(d, 1'b0)}, "pad idle");
      fault_one = 1'b1;
      idle(8);
      fault_one = 1'b0;
      idle(80);
      check({6'h00, pin.o, pin.oe}, {6'h00, exp_pin(d, 1'b1)}, "pad active");
      wr(`STBIRQ_OFS_CLEAR, 8'h02);
      idle(3);
      check({6'h00, pin.o, pin.oe}, {6'h00, exp_pin(d, 1'b0)}, "pad cleared");
      wr(`STBIRQ_OFS_UNMASK, 8'h00);
    end
  endtask

  task automatic test_event_wins();
    fault_one = 1'b1;
    wait_lat(2'b01);
    wr(`STBIRQ_OFS_CLEAR, 8'h02);
    rd_chk(`STBIRQ_OFS_STATUS, 8'h02);
    fault_one = 1'b0;
    idle(8);
    wr(`STBIRQ_OFS_CLEAR, 8'h02);
    wait_lat(2'b00);
  endtask

  initial begin
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    // Comparators sit below threshold until test_sticky raises a fault with the unmask bits still 0
    idle(2);
    test_regs();
    test_sticky(1);
    test_sticky(2);
    test_pulse();
    test_drive();
    test_event_wins();
    conclude();
  end
endmodule

// [verif/stbirq_far_model.sv]
// Purpose: Far-side model of the sense comparators and the pulled-up interrupt wire
// Assumes: Each comparator output follows the fault level the bench commands
// Notes: A released pad reads high through the pull-up, never as a stale value
module stbirq_far_model (
  input wire logic fault_one_in,
  input wire logic fault_two_in,
  input wire stbirq_pkg::stbirq_pin_t pad_in,
  output logic sense_pin_one_out,
  output logic sense_pin_two_out,
  output logic pad_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import stbirq_pkg::*;
  // Comparator high while the pin sits above its threshold
  assign sense_pin_one_out = fault_one_in;
  assign sense_pin_two_out = fault_two_in;
  assign pad_level_out = pad_in.oe ? pad_in.o : 1'b1;
endmodule
